/* File: rtl/attr_host_pkg.sv */
package attr_host_pkg;
  // Register byte addresses on the AXI4-Lite side.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] RDATA_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_ATTR  = 2;
  localparam int CTRL_LANE  = 3;

  // Status register fields.
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_REFUSE = 2;
  localparam int STAT_SPACE  = 4;

  // Card address bits that steer the attribute decode.
  localparam int A_ODD  = 0;
  localparam int A_CFG  = 9;
  localparam int A_HIGH = 10;

  // Lane selection codes held in the control register.
  localparam logic [1:0] LANE_LOW  = 2'h0;
  localparam logic [1:0] LANE_HIGH = 2'h1;
  localparam logic [1:0] LANE_WORD = 2'h2;

  // Space classes reported back in the status register.
  localparam logic [2:0] SP_COMMON = 3'h0;
  localparam logic [2:0] SP_INFO   = 3'h1;
  localparam logic [2:0] SP_OPTION = 3'h2;
  localparam logic [2:0] SP_STATE  = 3'h3;
  localparam logic [2:0] SP_PINSUB = 3'h4;
  localparam logic [2:0] SP_SOCKET = 3'h5;
  localparam logic [2:0] SP_OTHER  = 3'h6;

  // Strobe timing; least times round up to whole clock cycles.
  localparam int CLK_NS       = 4;
  localparam int SETUP_NS     = 30;
  localparam int STROBE_NS    = 150;
  localparam int HOLD_NS      = 20;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } phase_e;
endpackage

/* File: rtl/attribute_space_host.sv */
`timescale 1ns/1ns
// Functional notes
// (R1) Attribute read holds attribute select and output strobe low, write strobe high throughout.
// (R2) Attribute space takes only byte transfers at even addresses.
// (R3) Byte enables pick lanes, but attribute data is valid on the even lane only.
// (R4) Low enable alone with select high reads one common byte on lane 7..0.
// (R5) High enable alone with select high reads one common byte on lane 15..8.
// (R6) Both enables, select high, even address read a common word on 15..0.
// (R7) Common writes decode enables like reads; each enable alone writes its lane.
// (R8) Both enables, select high, even address write a common word on 15..0.
// (R9) Attribute read with A10, A9 and A0 low reaches the card information structure.
// (R10) Attribute access with A9 high, A0 low reaches the configuration registers.
// (R11) Configuration space with A8..A1 zero selects the option register.
// (R12) Configuration space with only A1 high selects the card state register.
// (R13) Configuration space with only A2 high selects the pin substitute register.
// (R14) Configuration space with A2 and A1 high selects socket and copy register.
// (R15) Attribute access at an odd address or high enable alone is invalid.
// (R16) Attribute write with low enable and A0 high is an invalid odd write.
// (R17) Host writes no attribute location outside the configuration registers; the code refuses only attribute writes with A9 low.
// (R18) Host takes configuration addresses from software, never as fixed values.
// (R19) Card ignores invalid accesses and leaves its state unchanged.
// (R20) Both enables high put the card in standby, ignoring all else.
module attribute_space_host (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Card memory bus.
  output logic [10:0]      card_addr,
  output logic             low_byte_enable_n,
  output logic             high_byte_enable_n,
  output logic             attr_select_n,
  output logic             out_strobe_n,
  output logic             write_strobe_n,
  input  wire logic [15:0] card_data_in,
  output logic [15:0]      card_data_out,
  output logic             card_data_oe
);

  // Refuses requests the card would treat as invalid or reserved.
  function automatic logic refused(input logic attr, input logic wr, input logic [1:0] lane,
                                   input logic [10:0] a);
    refused = 1'b0;
    if (attr && lane != attr_host_pkg::LANE_LOW) refused = 1'b1;   // [R2] [R15]
    if (attr && a[attr_host_pkg::A_ODD]) refused = 1'b1;           // [R15] [R16]
    if (attr && wr && !a[attr_host_pkg::A_CFG]) refused = 1'b1;    // [R17]
    if (!attr && lane == attr_host_pkg::LANE_WORD && a[attr_host_pkg::A_ODD]) begin
      refused = 1'b1;                                              // [R6] [R8]
    end
    if (lane > attr_host_pkg::LANE_WORD) refused = 1'b1;
  endfunction

  // Names the space the card decodes for an address, for software to inspect.
  function automatic logic [2:0] space_of(input logic attr, input logic [10:0] a);
    space_of = attr_host_pkg::SP_COMMON;
    if (attr) begin
      space_of = attr_host_pkg::SP_OTHER;
      if (!a[attr_host_pkg::A_HIGH] && !a[attr_host_pkg::A_CFG]) begin
        space_of = attr_host_pkg::SP_INFO;                         // [R9]
      end else if (a[attr_host_pkg::A_CFG] && a[8:3] == 6'h00) begin
        case (a[2:1])                                              // [R10]
          2'h0: space_of = attr_host_pkg::SP_OPTION;               // [R11]
          2'h1: space_of = attr_host_pkg::SP_STATE;                // [R12]
          2'h2: space_of = attr_host_pkg::SP_PINSUB;               // [R13]
          default: space_of = attr_host_pkg::SP_SOCKET;            // [R14]
        endcase
      end
    end
  endfunction

  // Merges the low two byte lanes of a bus write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  // Software-visible registers and bus channel state.
  logic [7:0]             aw_addr_reg;
  logic                   aw_full_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   w_full_reg;
  logic                   wr_fire;
  logic                   start_req;
  logic                   ctrl_write_reg;
  logic                   ctrl_attr_reg;
  logic [1:0]             ctrl_lane_reg;
  logic [10:0]            addr_reg;
  logic [15:0]            wdata_reg;
  logic [15:0]            rdata_reg;
  logic                   done_reg;
  logic                   refuse_reg;
  logic                   done_set;
  logic                   refuse_set;
  logic                   wr_mapped;
  attr_host_pkg::phase_e  phase_reg;
  logic [7:0]             cnt_reg;
  logic                   cnt_zero;

  // A write proceeds only once address and data are both held and no response waits.
  assign s_awready = !aw_full_reg;
  assign s_wready  = !w_full_reg;
  assign wr_fire   = aw_full_reg && w_full_reg && !s_bvalid;
  assign wr_mapped = aw_addr_reg == attr_host_pkg::CTRL_OFS || aw_addr_reg == attr_host_pkg::ADDR_OFS
                     || aw_addr_reg == attr_host_pkg::WDATA_OFS || aw_addr_reg == attr_host_pkg::STATUS_OFS;
  assign start_req = wr_fire && aw_addr_reg == attr_host_pkg::CTRL_OFS && w_strb_reg[0]
                     && w_data_reg[attr_host_pkg::CTRL_START];

  // Write address and data are captured independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= attr_host_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_mapped ? attr_host_pkg::RESP_OKAY : attr_host_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Request registers; they are frozen while a card cycle runs so pins stay stable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_write_reg <= 1'b0;
      ctrl_attr_reg  <= 1'b0;
      ctrl_lane_reg  <= attr_host_pkg::LANE_LOW;
      addr_reg       <= 11'h000;
      wdata_reg      <= 16'h0000;
    end else if (wr_fire && phase_reg == attr_host_pkg::ST_IDLE) begin
      if (aw_addr_reg == attr_host_pkg::CTRL_OFS && w_strb_reg[0]) begin
        ctrl_write_reg <= w_data_reg[attr_host_pkg::CTRL_WRITE];
        ctrl_attr_reg  <= w_data_reg[attr_host_pkg::CTRL_ATTR];
        ctrl_lane_reg  <= w_data_reg[attr_host_pkg::CTRL_LANE +: 2];
      end
      if (aw_addr_reg == attr_host_pkg::ADDR_OFS) begin
        addr_reg <= 11'(merge16({5'h00, addr_reg}, w_data_reg, w_strb_reg));  // [R18]
      end
      if (aw_addr_reg == attr_host_pkg::WDATA_OFS) begin
        wdata_reg <= merge16(wdata_reg, w_data_reg, w_strb_reg);
      end
    end
  end

  // A start carries the control fields written in the same word.
  logic                   go_write;
  logic                   go_attr;
  logic [1:0]             go_lane;
  logic                   go_ok;
  assign go_write = w_data_reg[attr_host_pkg::CTRL_WRITE];
  assign go_attr  = w_data_reg[attr_host_pkg::CTRL_ATTR];
  assign go_lane  = w_data_reg[attr_host_pkg::CTRL_LANE +: 2];
  assign go_ok    = start_req && phase_reg == attr_host_pkg::ST_IDLE
                    && !refused(go_attr, go_write, go_lane, addr_reg);
  assign refuse_set = start_req && phase_reg == attr_host_pkg::ST_IDLE
                      && refused(go_attr, go_write, go_lane, addr_reg);
  assign cnt_zero = cnt_reg == 8'h00;
  assign done_set = phase_reg == attr_host_pkg::ST_HOLD && cnt_zero;

  // Phase sequencer: address setup, strobe, then hold with strobes released.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= attr_host_pkg::ST_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      case (phase_reg)
        attr_host_pkg::ST_IDLE: begin
          if (go_ok) begin
            phase_reg <= attr_host_pkg::ST_SETUP;
            cnt_reg   <= 8'(attr_host_pkg::SETUP_CYC - 1);
          end
        end
        attr_host_pkg::ST_SETUP: begin
          if (cnt_zero) begin
            phase_reg <= attr_host_pkg::ST_STROBE;
            cnt_reg   <= 8'(attr_host_pkg::STROBE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        attr_host_pkg::ST_STROBE: begin
          if (cnt_zero) begin
            phase_reg <= attr_host_pkg::ST_HOLD;
            cnt_reg   <= 8'(attr_host_pkg::HOLD_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        attr_host_pkg::ST_HOLD: begin
          if (cnt_zero) begin
            phase_reg <= attr_host_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: phase_reg <= attr_host_pkg::ST_IDLE;
      endcase
    end
  end

  // Card pins; enables high in idle keep the card in standby between cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_byte_enable_n  <= 1'b1;
      high_byte_enable_n <= 1'b1;
      attr_select_n      <= 1'b1;
      out_strobe_n       <= 1'b1;
      write_strobe_n     <= 1'b1;
      card_addr          <= 11'h000;
      card_data_out      <= 16'h0000;
      card_data_oe       <= 1'b0;
    end else if (go_ok) begin
      card_addr          <= addr_reg;
      attr_select_n      <= !go_attr;
      low_byte_enable_n  <= go_lane == attr_host_pkg::LANE_HIGH;   // [R4] [R7]
      high_byte_enable_n <= go_lane == attr_host_pkg::LANE_LOW;    // [R5] [R7]
      card_data_out      <= wdata_reg;                             // [R8]
      card_data_oe       <= go_write;
    end else if (phase_reg == attr_host_pkg::ST_SETUP && cnt_zero) begin
      out_strobe_n   <= ctrl_write_reg;                            // [R1]
      write_strobe_n <= !ctrl_write_reg;                           // [R1]
    end else if (phase_reg == attr_host_pkg::ST_STROBE && cnt_zero) begin
      out_strobe_n   <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if (done_set) begin
      low_byte_enable_n  <= 1'b1;                                  // [R20]
      high_byte_enable_n <= 1'b1;
      attr_select_n      <= 1'b1;
      card_data_oe       <= 1'b0;
    end
  end

  // Read data is sampled on the last strobe cycle; attribute reads keep only the even lane.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 16'h0000;
    end else if (phase_reg == attr_host_pkg::ST_STROBE && cnt_zero && !ctrl_write_reg) begin
      if (ctrl_attr_reg) begin
        rdata_reg <= {8'h00, card_data_in[7:0]};                   // [R3]
      end else if (ctrl_lane_reg == attr_host_pkg::LANE_LOW) begin
        rdata_reg <= {8'h00, card_data_in[7:0]};                   // [R4]
      end else if (ctrl_lane_reg == attr_host_pkg::LANE_HIGH) begin
        rdata_reg <= {card_data_in[15:8], 8'h00};                  // [R5]
      end else begin
        rdata_reg <= card_data_in;                                 // [R6]
      end
    end
  end

  // Sticky flags: write one to clear, and a new event in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_reg   <= 1'b0;
      refuse_reg <= 1'b0;
    end else begin
      if (done_set) begin
        done_reg <= 1'b1;
      end else if (wr_fire && aw_addr_reg == attr_host_pkg::STATUS_OFS && w_strb_reg[0]
                   && w_data_reg[attr_host_pkg::STAT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (refuse_set) begin
        refuse_reg <= 1'b1;                                        // [R15] [R16] [R17]
      end else if (wr_fire && aw_addr_reg == attr_host_pkg::STATUS_OFS && w_strb_reg[0]
                   && w_data_reg[attr_host_pkg::STAT_REFUSE]) begin
        refuse_reg <= 1'b0;
      end
    end
  end

  // Read channel; one read at a time, answered the cycle after the address is taken.
  logic [31:0]            rd_word;
  logic                   rd_ok;
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    case (s_araddr)
      attr_host_pkg::CTRL_OFS: begin
        rd_word[attr_host_pkg::CTRL_WRITE]     = ctrl_write_reg;
        rd_word[attr_host_pkg::CTRL_ATTR]      = ctrl_attr_reg;
        rd_word[attr_host_pkg::CTRL_LANE +: 2] = ctrl_lane_reg;
      end
      attr_host_pkg::ADDR_OFS:  rd_word[10:0] = addr_reg;
      attr_host_pkg::WDATA_OFS: rd_word[15:0] = wdata_reg;
      attr_host_pkg::RDATA_OFS: rd_word[15:0] = rdata_reg;
      attr_host_pkg::STATUS_OFS: begin
        rd_word[attr_host_pkg::STAT_BUSY]      = phase_reg != attr_host_pkg::ST_IDLE;
        rd_word[attr_host_pkg::STAT_DONE]      = done_reg;
        rd_word[attr_host_pkg::STAT_REFUSE]    = refuse_reg;
        rd_word[attr_host_pkg::STAT_SPACE +: 3] = space_of(ctrl_attr_reg, addr_reg);
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= attr_host_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_word;
      s_rresp  <= rd_ok ? attr_host_pkg::RESP_OKAY : attr_host_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/attribute_space_host_assertions.sv */
`timescale 1ns/1ns
module attribute_space_host_assertions (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Card memory bus.
  input wire logic [10:0] card_addr,
  input wire logic        low_byte_enable_n,
  input wire logic        high_byte_enable_n,
  input wire logic        attr_select_n,
  input wire logic        out_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [15:0] card_data_out,
  input wire logic        card_data_oe
);
  logic       en_any;
  logic       idle;
  logic [7:0] strobe_cnt;
  // A lit lane enable means a card cycle runs; idle means neither strobe is low.
  assign en_any = !(low_byte_enable_n && high_byte_enable_n);
  assign idle   = out_strobe_n && write_strobe_n;
  // Strobe cycles are counted so the width is judged without a long repetition.
  always_ff @(posedge aclk) begin
    if (!aresetn || idle) strobe_cnt <= 8'h00;
    else strobe_cnt <= strobe_cnt + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_excl; !out_strobe_n |-> write_strobe_n && !card_data_oe; endproperty
  a_rd_excl: assert property (p_rd_excl) else $error("read strobe overlaps a write");
  property p_standby; !en_any |-> idle && attr_select_n && !card_data_oe; endproperty
  a_standby: assert property (p_standby) else $error("activity without a lane enable");
  property p_attr_byte; !attr_select_n |-> !low_byte_enable_n && high_byte_enable_n && !card_addr[0]; endproperty
  a_attr_byte: assert property (p_attr_byte) else $error("attribute access not an even byte");
  property p_attr_wr; !attr_select_n && !write_strobe_n |-> card_addr[9]; endproperty
  a_attr_wr: assert property (p_attr_wr) else $error("attribute write outside the registers");
  property p_word_even; !low_byte_enable_n && !high_byte_enable_n |-> !card_addr[0]; endproperty
  a_word_even: assert property (p_word_even) else $error("word access at an odd address");
  property p_wr_data; !write_strobe_n |-> card_data_oe && $stable(card_data_out); endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not driven steadily");
  property p_setup; $rose(en_any) |-> idle [*8] ##1 !idle; endproperty
  a_setup: assert property (p_setup) else $error("strobe setup length wrong");
  property p_width; idle && strobe_cnt != 8'h00 |-> strobe_cnt == 8'(attr_host_pkg::STROBE_CYC); endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_hold; $rose(idle) |-> en_any [*5] ##1 !en_any; endproperty
  a_hold: assert property (p_hold) else $error("enable hold length wrong");
  // Main scenarios.
  c_attr_rd: cover property (!attr_select_n && !out_strobe_n);
  c_attr_wr: cover property (!attr_select_n && !write_strobe_n);
  c_word_wr: cover property (!low_byte_enable_n && !high_byte_enable_n && !write_strobe_n);
endmodule
bind attribute_space_host attribute_space_host_assertions attribute_space_host_assertions_i (
  .aclk(aclk), .aresetn(aresetn), .card_addr(card_addr), .low_byte_enable_n(low_byte_enable_n),
  .high_byte_enable_n(high_byte_enable_n), .attr_select_n(attr_select_n), .out_strobe_n(out_strobe_n),
  .write_strobe_n(write_strobe_n), .card_data_out(card_data_out), .card_data_oe(card_data_oe));

/* File: tb/card_model.sv */
`timescale 1ns/1ns
module card_model (
  // Clock.
  input  wire logic        aclk,
  // Card memory bus.
  input  wire logic [10:0] card_addr,
  input  wire logic        low_byte_enable_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        attr_select_n,
  input  wire logic        out_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [15:0] card_data_out,
  input  wire logic        card_data_oe,
  output logic [15:0]      card_data_in
);
  logic [7:0]  mem [0:2047];
  logic [7:0]  cfg_reg [0:3];
  logic [15:0] last_reg = 16'h0000;
  logic [15:0] rd_val;
  logic        stby;
  logic        bad;
  logic        cfg_sel;
  logic        info_sel;
  // Space decode; odd or high-lane-only attribute cycles select nothing.
  assign stby     = low_byte_enable_n && high_byte_enable_n;
  assign bad      = !attr_select_n && (card_addr[0] || low_byte_enable_n);
  assign cfg_sel  = !attr_select_n && !bad && card_addr[9] && card_addr[8:3] == 6'h00;
  assign info_sel = !attr_select_n && !bad && card_addr[10:9] == 2'h0;
  // Lanes the card leaves alone show the inverse of the last bus value, so stale data never matches.
  always_comb begin
    rd_val = ~last_reg;
    if (attr_select_n && !low_byte_enable_n) rd_val[7:0] = mem[card_addr];
    if (attr_select_n && !high_byte_enable_n) rd_val[15:8] = mem[card_addr | 11'h001];
    if (cfg_sel) rd_val[7:0] = cfg_reg[card_addr[2:1]];
    if (info_sel) rd_val[7:0] = card_addr[8:1] ^ 8'h5A;
  end
  assign card_data_in = (!stby && !out_strobe_n && write_strobe_n) ? rd_val : ~last_reg;
  // Writes land on every strobe cycle; info structure writes are dropped.
  always @(posedge aclk) begin
    last_reg <= card_data_in;
    if (!stby && !write_strobe_n && out_strobe_n && card_data_oe) begin
      if (attr_select_n && !low_byte_enable_n) mem[card_addr] <= card_data_out[7:0];
      if (attr_select_n && !high_byte_enable_n) mem[card_addr | 11'h001] <= card_data_out[15:8];
      if (cfg_sel) cfg_reg[card_addr[2:1]] <= card_data_out[7:0];
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} exp_s;
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid;
  logic        s_arready, s_rvalid, s_rready, low_byte_enable_n, high_byte_enable_n, attr_select_n;
  logic        out_strobe_n, write_strobe_n, card_data_oe;
  logic [1:0]  s_bresp, s_rresp;
  logic [3:0]  s_wstrb;
  logic [7:0]  s_awaddr, s_araddr;
  logic [7:0]  v [0:3];
  logic [4:0]  bad_c [0:5] = '{5'h0D, 5'h05, 5'h07, 5'h07, 5'h11, 5'h19};
  logic [10:0] bad_a [0:5] = '{11'h200, 11'h203, 11'h201, 11'h010, 11'h001, 11'h000};
  logic [10:0] card_addr, a;
  logic [15:0] card_data_in, card_data_out, d, w;
  logic [31:0] s_wdata, s_rdata, rdv;
  exp_s        exp_q [$];
  exp_s        e;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Every port meets the bench signal of the same name.
  attribute_space_host attribute_space_host_i (.*);
  card_model card_model_i (.*);
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d.", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, input logic [33:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, s, x);
    end
  endtask
  // Write: address and data offered together, each dropped once taken, bready held until the answer.
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] r = attr_host_pkg::RESP_OKAY);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    exp_q.push_back('{r, 32'h0, 32'h0});
    s_awaddr <= ad;
    s_wdata <= dt;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done = aw_done || s_awready;
      w_done = w_done || s_wready;
      s_awvalid <= !aw_done;
      s_wvalid <= !w_done;
    end
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  // Read with the expected answer noted first; rdv keeps the data for polling.
  task automatic rc(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] m,
                    input logic [1:0] r = attr_host_pkg::RESP_OKAY);
    @(posedge aclk);
    exp_q.push_back('{r, x, m});
    s_araddr <= ad;
    {s_arvalid, s_rready} <= 2'h3;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_rvalid);
    rdv = s_rdata;
    s_rready <= 1'b0;
  endtask
  // One card cycle: load address and data, start, poll until idle, check and clear the flags.
  task automatic op(input logic [4:0] c, input logic [10:0] ad, input logic [15:0] wd, input logic [6:0] st,
                    input logic [6:0] m);
    int n;
    n = 0;
    wr(attr_host_pkg::ADDR_OFS, {21'h0, ad});
    wr(attr_host_pkg::WDATA_OFS, {16'h0, wd});
    wr(attr_host_pkg::CTRL_OFS, {27'h0, c});
    do begin
      rc(attr_host_pkg::STATUS_OFS, 32'h0, 32'h0);
      n++;
    end while (rdv[attr_host_pkg::STAT_BUSY] !== 1'b0 && n < 60);
    rc(attr_host_pkg::STATUS_OFS, {25'h0, st}, {25'h0, m});
    wr(attr_host_pkg::STATUS_OFS, 32'h6);
  endtask
  // The oldest note is compared with each answer as it completes.
  always @(posedge aclk) begin
    if ((s_bvalid && s_bready) || (s_rvalid && s_rready)) begin
      e = exp_q.pop_front();
      chk(s_rvalid ? {s_rresp, s_rdata & e.mask} : {s_bresp, 32'h0}, {e.resp, e.data & e.mask});
    end
  end
  // A hang is cut short well past the expected run length.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(32'h53C0370C));
    rc(attr_host_pkg::STATUS_OFS, 32'h0, 32'h77);
    // Common memory: lanes written apart and read as a word, then the reverse.
    a = 11'($urandom % 1024) << 1;
    d = 16'($urandom);
    w = 16'($urandom);
    op(5'h03, a, d, 7'h02, 7'h77);
    op(5'h0B, a, ~d, 7'h02, 7'h77);
    op(5'h11, a, 16'h0000, 7'h02, 7'h77);
    rc(attr_host_pkg::RDATA_OFS, {16'h0, ~d[15:8], d[7:0]}, 32'hFFFF);
    op(5'h13, a, w, 7'h02, 7'h77);
    op(5'h01, a | 11'h001, 16'h0000, 7'h02, 7'h77);
    rc(attr_host_pkg::RDATA_OFS, {24'h0, w[15:8]}, 32'hFF);
    op(5'h09, a, 16'h0000, 7'h02, 7'h77);
    rc(attr_host_pkg::RDATA_OFS, {16'h0, w[15:8], 8'h00}, 32'hFF00);
    $display("Test common memory finished.");
    // Configuration registers: all four written, then all four read back; upper data must be zero.
    for (int i = 0; i < 8; i++) begin
      if (i < 4) v[i] = 8'($urandom);
      op(i < 4 ? 5'h07 : 5'h05, 11'h200 | 11'(i % 4 << 1), {8'h00, v[i % 4]},
         {3'(attr_host_pkg::SP_OPTION + 3'(i % 4)), 4'h2}, 7'h77);
      if (i >= 4) rc(attr_host_pkg::RDATA_OFS, {24'h0, v[i % 4]}, 32'hFFFFFFFF);
    end
    op(5'h05, 11'h014, 16'h0000, {attr_host_pkg::SP_INFO, 4'h2}, 7'h77);
    rc(attr_host_pkg::RDATA_OFS, 32'h50, 32'hFFFFFFFF);
    op(5'h05, 11'h402, 16'h0000, {attr_host_pkg::SP_OTHER, 4'h2}, 7'h77);
    $display("Test attribute space finished.");
    // Invalid requests are turned away with no card cycle; the option register must survive.
    for (int k = 0; k < 6; k++) op(bad_c[k], bad_a[k], {8'h00, ~v[0]}, 7'h04, 7'h07);
    op(5'h05, 11'h200, 16'h0000, 7'h22, 7'h77);
    rc(attr_host_pkg::RDATA_OFS, {24'h0, v[0]}, 32'hFF);
    rc(attr_host_pkg::CTRL_OFS, 32'h4, 32'h1E);
    $display("Test refused requests finished.");
    // Unmapped and read-only offsets answer with an error.
    wr(8'h20, 32'h0, attr_host_pkg::RESP_SLVERR);
    wr(attr_host_pkg::RDATA_OFS, 32'h0, attr_host_pkg::RESP_SLVERR);
    rc(8'h20, 32'h0, 32'h0, attr_host_pkg::RESP_SLVERR);
    $display("Test register bus finished.");
    close_out();
  end
endmodule
